//--- shared/pwmss_pkg.sv
// Constants, register map and timing table for the PWM start/stop control block
//
// Notes on behaviour
// - Four byte-wide edge delay registers at consecutive locations, one per channel.
// - Delay registers reset to 0xac, 0x54, 0xac, 0x54.
// - Group channels stay idle after leaving shutdown, only while control bit D5 is zero.
// - Group bits D3..D0 mark channels 4..1; each resets to zero.
// - Entering or leaving shutdown, or a power-down change, runs the soft period.
// - Period code bits D4:D3 both zero skips the 50% interval.
// - Five-bit code picks 16.5 ms up to 13196.4 ms; default 01111 is 125.7 ms.
// - Interval lengths are approximate.
// - Control bit D6 one holds outputs in hard shutdown; zero starts playback.
package pwmss_pkg;

    localparam int ADDR_W = 8;
    localparam int IDX_W = 6;
    localparam int NCH = 4;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_SYS_CTRL2 = 6'h05;
    localparam logic [IDX_W-1:0] IDX_DLY_CH1 = 6'h11;
    localparam logic [IDX_W-1:0] IDX_DLY_CH2 = 6'h12;
    localparam logic [IDX_W-1:0] IDX_DLY_CH1_INV = 6'h13;
    localparam logic [IDX_W-1:0] IDX_DLY_CH2_INV = 6'h14;
    localparam logic [IDX_W-1:0] IDX_IDLE_GROUP = 6'h19;
    localparam logic [IDX_W-1:0] IDX_SOFT_PERIOD = 6'h1a;
    localparam logic [IDX_W-1:0] IDX_STATUS = 6'h3f;

    // Reset values
    localparam logic [7:0] RST_SYS_CTRL2 = 8'h40;
    localparam logic [7:0] RST_DLY_CH1 = 8'hac;
    localparam logic [7:0] RST_DLY_CH2 = 8'h54;
    localparam logic [7:0] RST_IDLE_GROUP = 8'h30;
    localparam logic [7:0] RST_SOFT_PERIOD = 8'h0f;

    // Field positions
    localparam int SC2_SHUTDOWN_BIT = 6;
    localparam int SC2_GROUP_OFF_BIT = 5;
    localparam int SSP_DISABLE_BIT = 7;
    localparam int SSP_CODE_MSB = 4;
    localparam int SSP_CODE_LSB = 0;
    localparam int DLY_VAL_MSB = 7;
    localparam int DLY_VAL_LSB = 2;
    localparam int GRP_MSB = 3;

    // Delay: (value + 32) * 4 delay-clock cycles, so -32 maps to the shortest tap
    localparam logic [7:0] DLY_BIAS = 8'h20;
    localparam int DLY_STEP_SHIFT = 2;
    localparam int DLY_LINE_LEN = 256;

    // Timing: interval table is held in tenths of a millisecond
    localparam int CLK_PERIOD_NS = 100;
    localparam int TENTH_MS_NS = 100000;
    localparam int TENTH_MS_CYCLES = TENTH_MS_NS / CLK_PERIOD_NS;
    localparam int TENTHS_W = 18;
    localparam logic [3:0] HALF_DUTY_CYCLES = 4'h8;

    typedef enum logic [3:0] {
        ST_OFF = 4'b0001,
        ST_START = 4'b0010,
        ST_RUN = 4'b0100,
        ST_STOP = 4'b1000
    } pwmss_state_t;

    // Interval in tenths of a millisecond for codes 01000..11111
    function automatic logic [TENTHS_W-1:0] pwmss_tenths(input logic [4:0] code);
        logic [TENTHS_W-1:0] t;
        t = 18'h00000;
        case (code)
            5'h08: t = 18'd165;
            5'h09: t = 18'd239;
            5'h0a: t = 18'd314;
            5'h0b: t = 18'd404;
            5'h0c: t = 18'd539;
            5'h0d: t = 18'd703;
            5'h0e: t = 18'd942;
            5'h0f: t = 18'd1257;
            5'h10: t = 18'd1646;
            5'h11: t = 18'd2394;
            5'h12: t = 18'd3142;
            5'h13: t = 18'd4039;
            5'h14: t = 18'd5386;
            5'h15: t = 18'd7031;
            5'h16: t = 18'd9425;
            5'h17: t = 18'd12566;
            5'h18: t = 18'd17281;
            5'h19: t = 18'd25136;
            5'h1a: t = 18'd32991;
            5'h1b: t = 18'd42417;
            5'h1c: t = 18'd56556;
            5'h1d: t = 18'd73837;
            5'h1e: t = 18'd98973;
            5'h1f: t = 18'd131964;
            default: t = 18'h00000;
        endcase
        return t;
    endfunction

endpackage

//--- logic/pwmss_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module pwmss_sync
    import pwmss_pkg::*;
(
    // Clock and control
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Asynchronous input and filtered level
    input wire logic async_i,
    output logic level_o
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            s1_reg <= async_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Level changes once the second and third stages agree
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            level_o <= 1'b0;
        else if (ce_i && (s2_reg == s3_reg))
            level_o <= s3_reg;
    end
endmodule

//--- logic/pwmss_edge_delay.sv
// Programmable edge delay line for one PWM channel
`timescale 1ns/100ps
module pwmss_edge_delay
    import pwmss_pkg::*;
(
    // Clock and control
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Signed delay setting and signal
    input wire logic [7:0] setting_i,
    input wire logic pwm_i,
    output logic pwm_o
);
    logic [DLY_LINE_LEN-1:0] line_reg;
    logic [7:0] tap;

    // Signed value in D7:D2 biased so the most negative value is the shortest tap
    always_comb
    begin
        tap = 8'((8'({{2{setting_i[DLY_VAL_MSB]}}, setting_i[DLY_VAL_MSB:DLY_VAL_LSB]})
            + DLY_BIAS) << DLY_STEP_SHIFT);
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            line_reg <= '0;
        else if (ce_i)
            line_reg <= {line_reg[DLY_LINE_LEN-2:0], pwm_i};
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            pwm_o <= 1'b0;
        else if (ce_i)
            pwm_o <= line_reg[tap];
    end
endmodule

//--- logic/pwmss_top.sv
// PWM channel start/stop control: registers, soft period timer and output gating
`timescale 1ns/100ps
module pwmss_top
    import pwmss_pkg::*;
#(
    parameter int TENTH_CYCLES = TENTH_MS_CYCLES
)
(
    // Clock, reset, clock enable
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Power-down pin, asynchronous
    input wire logic power_down_input_i,
    // Modulator channels: ch1, ch2, ch1 inverted, ch2 inverted
    input wire logic [NCH-1:0] pwm_in_i,
    // Gated PWM outputs and per-channel drive
    output logic [NCH-1:0] pwm_out_o,
    output logic [NCH-1:0] pwm_active_o,
    output logic soft_ramp_busy_o
);
    logic [7:0] sys_ctrl2_reg;
    logic [7:0] dly_reg [NCH];
    logic [7:0] idle_group_reg;
    logic [7:0] soft_period_reg;
    logic wait_reg;
    logic [IDX_W-1:0] idx;
    logic aligned;
    logic wr_ok;
    logic pd_level;
    logic pd_seen_reg;
    logic pd_change;
    logic shutdown_req;
    logic [NCH-1:0] delayed;
    logic [NCH-1:0] idle_mask_reg;
    logic [NCH-1:0] idle_mask_next;
    pwmss_state_t state_reg;
    pwmss_state_t state_next;
    logic [TENTHS_W-1:0] tenths_reg;
    logic [15:0] pre_reg;
    logic period_on;
    logic [TENTHS_W-1:0] period_tenths;
    logic timer_done;
    logic [3:0] half_cnt_reg;
    logic fifty_reg;
    logic [31:0] rd_word;

    assign idx = avs_address_i[ADDR_W-1:2];
    assign aligned = (avs_address_i[1:0] == 2'b00);

    // Write takes effect at the edge where waitrequest is sampled low
    assign wr_ok = avs_write_i && !wait_reg && aligned && avs_byteenable_i[0];

    // One wait state on every access; waitrequest idles high
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            wait_reg <= 1'b1;
        else if (ce_i)
        begin
            if ((avs_read_i || avs_write_i) && wait_reg)
                wait_reg <= 1'b0;
            else
                wait_reg <= 1'b1;
        end
    end

    assign avs_waitrequest_o = wait_reg;

    // Read mux, unmapped addresses read as zero
    always_comb
    begin
        rd_word = 32'h0000_0000;
        if (aligned)
        begin
            case (idx)
                IDX_SYS_CTRL2: rd_word = {24'h000000, sys_ctrl2_reg};
                IDX_DLY_CH1: rd_word = {24'h000000, dly_reg[0]};
                IDX_DLY_CH2: rd_word = {24'h000000, dly_reg[1]};
                IDX_DLY_CH1_INV: rd_word = {24'h000000, dly_reg[2]};
                IDX_DLY_CH2_INV: rd_word = {24'h000000, dly_reg[3]};
                IDX_IDLE_GROUP: rd_word = {24'h000000, idle_group_reg};
                IDX_SOFT_PERIOD: rd_word = {24'h000000, soft_period_reg};
                IDX_STATUS: rd_word = {24'h000000, idle_mask_reg, state_reg};
                default: rd_word = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            avs_readdata_o <= 32'h0000_0000;
        else if (ce_i && avs_read_i && wait_reg)
            avs_readdata_o <= rd_word;
    end

    // Control register: D6 hard shutdown, D5 disables idle group
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            sys_ctrl2_reg <= RST_SYS_CTRL2;
        else if (ce_i && wr_ok && (idx == IDX_SYS_CTRL2))
            sys_ctrl2_reg <= avs_writedata_i[7:0];
    end

    // Edge delay registers at consecutive indices
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            dly_reg[0] <= RST_DLY_CH1;
            dly_reg[1] <= RST_DLY_CH2;
            dly_reg[2] <= RST_DLY_CH1;
            dly_reg[3] <= RST_DLY_CH2;
        end
        else if (ce_i && wr_ok)
        begin
            // Loaded by software, e.g. the three-state set, before leaving shutdown
            case (idx)
                IDX_DLY_CH1: dly_reg[0] <= avs_writedata_i[7:0];
                IDX_DLY_CH2: dly_reg[1] <= avs_writedata_i[7:0];
                IDX_DLY_CH1_INV: dly_reg[2] <= avs_writedata_i[7:0];
                IDX_DLY_CH2_INV: dly_reg[3] <= avs_writedata_i[7:0];
                default: ;
            endcase
        end
    end

    // Idle group register
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            idle_group_reg <= RST_IDLE_GROUP;
        else if (ce_i && wr_ok && (idx == IDX_IDLE_GROUP))
            idle_group_reg <= avs_writedata_i[7:0];
    end

    // Soft period register
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            soft_period_reg <= RST_SOFT_PERIOD;
        else if (ce_i && wr_ok && (idx == IDX_SOFT_PERIOD))
            soft_period_reg <= avs_writedata_i[7:0];
    end

    pwmss_sync u_pd_sync (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .async_i(power_down_input_i),
        .level_o(pd_level)
    );

    // Per-channel edge delay
    genvar g;
    generate
        for (g = 0; g < NCH; g++)
        begin : gen_delay
            pwmss_edge_delay u_delay (
                .core_clk_i(core_clk_i),
                .rst_i(rst_i),
                .ce_i(ce_i),
                .setting_i(dly_reg[g]),
                .pwm_i(pwm_in_i[g]),
                .pwm_o(delayed[g])
            );
        end
    endgenerate

    assign shutdown_req = sys_ctrl2_reg[SC2_SHUTDOWN_BIT] || pd_level;

    // Track power-down level so that a change during run starts a soft period
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            pd_seen_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            pd_seen_reg <= pd_level;
        end
    end

    assign pd_change = (pd_seen_reg != pd_level);

    // Period selection: disabled timer or code D4:D3 = 00 gives no interval
    assign period_on = !soft_period_reg[SSP_DISABLE_BIT]
        && (soft_period_reg[SSP_CODE_MSB:SSP_CODE_MSB-1] != 2'b00);
    assign period_tenths = pwmss_tenths(soft_period_reg[SSP_CODE_MSB:SSP_CODE_LSB]);
    assign timer_done = (tenths_reg == '0);

    // Idle mask latched on leaving shutdown; D5 set releases every channel
    always_comb
    begin
        idle_mask_next = '0;
        if (!sys_ctrl2_reg[SC2_GROUP_OFF_BIT])
            idle_mask_next = idle_group_reg[GRP_MSB:0];
    end

    // Stop runs to its end even if shutdown is released meanwhile
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_OFF:
            begin
                if (!shutdown_req)
                    state_next = period_on ? ST_START : ST_RUN;
            end
            ST_START:
            begin
                if (shutdown_req)
                    state_next = period_on ? ST_STOP : ST_OFF;
                else if (timer_done)
                    state_next = ST_RUN;
            end
            ST_RUN:
            begin
                if (shutdown_req || pd_change)
                    state_next = period_on ? ST_STOP : ST_OFF;
            end
            ST_STOP:
            begin
                if (timer_done)
                    state_next = ST_OFF;
            end
            default: state_next = ST_OFF;
        endcase
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            state_reg <= ST_OFF;
        else if (ce_i)
            state_reg <= state_next;
    end

    // Mask held for the whole start, run and stop sequence
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            idle_mask_reg <= '0;
        else if (ce_i && (state_reg == ST_OFF) && (state_next != ST_OFF))
            idle_mask_reg <= idle_mask_next;
    end

    // Soft timer: prescaler of one tenth ms, then count down the tenths
    // Reloaded on every state change; the count only matters in start and stop
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            tenths_reg <= '0;
            pre_reg <= '0;
        end
        else if (ce_i)
        begin
            if (state_next != state_reg)
            begin
                tenths_reg <= period_tenths;
                pre_reg <= '0;
            end
            else if (!timer_done)
            begin
                if (pre_reg == 16'(TENTH_CYCLES - 1))
                begin
                    pre_reg <= '0;
                    tenths_reg <= tenths_reg - 1'b1;
                end
                else
                    pre_reg <= pre_reg + 1'b1;
            end
        end
    end

    // Square wave used as the 50% duty output during the soft period
    // Free-running, so the first half period after a start may be short
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            half_cnt_reg <= '0;
            fifty_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            if (half_cnt_reg == HALF_DUTY_CYCLES - 1'b1)
            begin
                half_cnt_reg <= '0;
                fifty_reg <= !fifty_reg;
            end
            else
                half_cnt_reg <= half_cnt_reg + 1'b1;
        end
    end

    // Output gating
    // Outputs follow the registered state, one cycle behind it
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            pwm_out_o <= '0;
            pwm_active_o <= '0;
            soft_ramp_busy_o <= 1'b0;
        end
        else if (ce_i)
        begin
            soft_ramp_busy_o <= (state_reg == ST_START) || (state_reg == ST_STOP);
            case (state_reg)
                ST_RUN:
                begin
                    pwm_active_o <= ~idle_mask_reg;
                    pwm_out_o <= delayed & ~idle_mask_reg;
                end
                ST_START, ST_STOP:
                begin
                    pwm_active_o <= ~idle_mask_reg;
                    pwm_out_o <= {NCH{fifty_reg}} & ~idle_mask_reg;
                end
                default:
                begin
                    pwm_active_o <= '0;
                    pwm_out_o <= '0;
                end
            endcase
        end
    end
endmodule

//--- tb/pwmss_monitor.sv
// Concurrent checks on the ports of the PWM start/stop control block
`timescale 1ns/100ps
module pwmss_monitor
    import pwmss_pkg::*;
#(
    parameter int TENTH_CYCLES = TENTH_MS_CYCLES
)
(
    // Clock and control
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Register bus
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    // Pins and channels
    input wire logic power_down_input_i,
    input wire logic [NCH-1:0] pwm_out_o,
    input wire logic [NCH-1:0] pwm_active_o,
    input wire logic soft_ramp_busy_o
);
    default clocking mon_cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    // Square wave holds eight cycles high unless the soft period ends first
    property square_p;
        $rose(pwm_out_o[0]) && soft_ramp_busy_o && $past(soft_ramp_busy_o)
        |-> (pwm_out_o[0] [*8] ##1 !pwm_out_o[0]) or (##[1:9] !soft_ramp_busy_o);
    endproperty

    sequence pd_held_s;
        $rose(power_down_input_i) && (pwm_active_o != 4'h0) && !soft_ramp_busy_o
        ##1 power_down_input_i [*4];
    endsequence

    wait_one_a: assert property ($fell(avs_waitrequest_o) |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    answer_bound_a: assert property (
        (avs_read_i || avs_write_i) && avs_waitrequest_o && ce_i |=> !avs_waitrequest_o)
        else $error("request not answered after one wait state");
    idle_wait_a: assert property (!avs_read_i && !avs_write_i |=> avs_waitrequest_o)
        else $error("waitrequest low without a request");
    read_upper_a: assert property (avs_readdata_o[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    idle_low_a: assert property ((pwm_out_o & ~pwm_active_o) == 4'h0)
        else $error("idle channel output not low");
    half_duty_a: assert property (square_p)
        else $error("soft period square wave not eight cycles high");
    pd_stop_a: assert property (pd_held_s |-> ##[0:8]
        (soft_ramp_busy_o || pwm_active_o == 4'h0))
        else $error("power-down did not stop the outputs");
    reset_idle_a: assert property (disable iff (1'b0) rst_i |=>
        avs_waitrequest_o && pwm_active_o == 4'h0 && pwm_out_o == 4'h0 && !soft_ramp_busy_o)
        else $error("outputs not idle after reset");

    cover property ($rose(soft_ramp_busy_o));
    cover property ($fell(avs_waitrequest_o) && avs_read_i);
    cover property (pd_held_s);
endmodule

bind pwmss_top pwmss_monitor #(.TENTH_CYCLES(TENTH_CYCLES)) mon_u (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .power_down_input_i(power_down_input_i),
    .pwm_out_o(pwm_out_o),
    .pwm_active_o(pwm_active_o),
    .soft_ramp_busy_o(soft_ramp_busy_o)
);

//--- tb/tb_top.sv
// Self-checking bench for the PWM start/stop control block
`timescale 1ns/100ps
module tb_top
    import pwmss_pkg::*;
;
    localparam int TC = 2;
    localparam int P_LO = 165 * TC;
    localparam int P_HI = P_LO + 6;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic [ADDR_W-1:0] avs_address_i = 8'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h00000000;
    logic [3:0] avs_byteenable_i = 4'h0;
    logic power_down_input_i = 1'b0;
    logic [NCH-1:0] pwm_in_i = 4'h0;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic [NCH-1:0] pwm_out_o;
    logic [NCH-1:0] pwm_active_o;
    logic soft_ramp_busy_o;
    int failures = 0;
    int comparisons = 0;
    int busy_cycles = 0;

    always #50 core_clk_i = ~core_clk_i;

    always @(posedge core_clk_i)
        if (soft_ramp_busy_o === 1'b1)
            busy_cycles++;

    pwmss_top #(.TENTH_CYCLES(TC)) dut_u (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o),
        .power_down_input_i(power_down_input_i),
        .pwm_in_i(pwm_in_i),
        .pwm_out_o(pwm_out_o),
        .pwm_active_o(pwm_active_o),
        .soft_ramp_busy_o(soft_ramp_busy_o)
    );

    task automatic end_sim();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One Avalon transfer; request held until waitrequest is seen low
    task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                            input logic [3:0] be, output logic [31:0] q);
        int n;
        @(posedge core_clk_i);
        avs_address_i <= a;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        avs_writedata_i <= {24'h000000, d};
        avs_byteenable_i <= be;
        for (n = 0; n < 20; n++)
        begin
            @(posedge core_clk_i);
            if (avs_waitrequest_o === 1'b0)
                break;
        end
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        if (n == 20)
        begin
            check(32'h00000000, 32'h00000001, "bus wait timeout");
            end_sim();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus_xfer(1'b1, a, d, 4'h1, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [31:0] q;
        bus_xfer(1'b0, a, 8'h00, 4'hf, q);
        check(q, {24'h000000, exp}, what);
    endtask

    // Waits for a soft period and checks its length in cycles
    task automatic busy_run();
        int n;
        int len;
        for (n = 0; n < 30; n++)
        begin
            @(posedge core_clk_i);
            if (soft_ramp_busy_o === 1'b1)
                break;
        end
        for (len = 0; len < 400 && soft_ramp_busy_o === 1'b1; len++)
            @(posedge core_clk_i);
        check({31'h00000000, len >= P_LO && len <= P_HI}, 32'h00000001, "soft period length");
    endtask

    task automatic wait_active(input logic [3:0] exp);
        int n;
        for (n = 0; n < 40 && pwm_active_o !== exp; n++)
            @(posedge core_clk_i);
        check({28'h0000000, pwm_active_o}, {28'h0000000, exp}, "channel active mask");
    endtask

    task automatic test_reset();
        int i;
        logic [7:0] rv[4] = '{8'hac, 8'h54, 8'hac, 8'h54};
        rd(8'h14, 8'h40, "control reset");
        for (i = 0; i < 4; i++)
            rd(8'h44 + 8'(4 * i), rv[i], "delay reset");
        rd(8'h64, 8'h30, "idle group reset");
        rd(8'h68, 8'h0f, "period reset");
        rd(8'hfc, 8'h01, "status after reset");
        check({28'h0000000, pwm_active_o}, 32'h00000000, "idle after reset");
        $display("test reset values done");
    endtask

    task automatic test_regs();
        int i;
        logic [31:0] q;
        logic [7:0] bd[4] = '{8'hb8, 8'h60, 8'ha0, 8'h48};
        for (i = 0; i < 4; i++)
            wr(8'h44 + 8'(4 * i), bd[i]);
        for (i = 0; i < 4; i++)
            rd(8'h44 + 8'(4 * i), bd[i], "delay readback");
        bus_xfer(1'b1, 8'h44, 8'h11, 4'he, q);
        rd(8'h44, 8'hb8, "write without byte lane");
        wr(8'h3c, 8'h5a);
        rd(8'h3c, 8'h00, "unmapped read");
        rd(8'h45, 8'h00, "unaligned read");
        $display("test register access done");
    endtask

    task automatic test_start_masked();
        int n;
        int t0;
        int t2;
        wr(8'h44, 8'h80);
        wr(8'h4c, 8'h7c);
        wr(8'h64, 8'h3a);
        wr(8'h68, 8'h08);
        wr(8'h14, 8'h00);
        busy_run();
        wait_active(4'h5);
        rd(8'hfc, 8'ha4, "status in run");
        repeat (4) @(posedge core_clk_i);
        pwm_in_i <= 4'hf;
        t0 = -1;
        t2 = -1;
        for (n = 0; n < 400; n++)
        begin
            @(posedge core_clk_i);
            if (t0 < 0 && pwm_out_o[0] === 1'b1)
                t0 = n;
            if (t2 < 0 && pwm_out_o[2] === 1'b1)
                t2 = n;
        end
        check(32'(t2 - t0), 32'd252, "edge delay spread");
        pwm_in_i <= 4'h0;
        $display("test masked start done");
    endtask

    task automatic test_stop();
        wr(8'h14, 8'h40);
        busy_run();
        wait_active(4'h0);
        $display("test stop done");
    endtask

    // Start and stop with no soft period expected
    task automatic test_quick(input logic [7:0] period, input logic [7:0] ctrl,
                              input logic [3:0] exp);
        int b;
        b = busy_cycles;
        wr(8'h68, period);
        wr(8'h14, ctrl);
        wait_active(exp);
        wr(8'h14, ctrl | 8'h40);
        wait_active(4'h0);
        check(32'(busy_cycles - b), 32'h00000000, "unexpected soft period");
        $display("test quick cycle done");
    endtask

    task automatic test_power_down();
        wr(8'h68, 8'h08);
        wr(8'h14, 8'h00);
        busy_run();
        @(posedge core_clk_i);
        power_down_input_i <= 1'b1;
        busy_run();
        wait_active(4'h0);
        @(posedge core_clk_i);
        power_down_input_i <= 1'b0;
        busy_run();
        wait_active(4'h5);
        $display("test power-down done");
    endtask

    // Clock enable low must freeze the delay lines and the outputs
    task automatic test_freeze();
        int n;
        ce_i <= 1'b0;
        pwm_in_i <= 4'hf;
        repeat (10) @(posedge core_clk_i);
        check({28'h0000000, pwm_out_o}, 32'h00000000, "output moved while frozen");
        ce_i <= 1'b1;
        for (n = 0; n < 10 && pwm_out_o[0] !== 1'b1; n++)
            @(posedge core_clk_i);
        check({28'h0000000, pwm_out_o}, 32'h00000001, "output after unfreeze");
        pwm_in_i <= 4'h0;
        $display("test clock enable done");
    endtask

    initial
    begin
        repeat (12) @(posedge core_clk_i);
        rst_i <= 1'b0;
        @(posedge core_clk_i);
        test_reset();
        test_regs();
        test_start_masked();
        test_stop();
        test_quick(8'h80, 8'h20, 4'hf);
        test_quick(8'h00, 8'h00, 4'h5);
        test_power_down();
        test_freeze();
        end_sim();
    end
endmodule
